// [verilog/uvep_pkg.sv]
// constants, pin bundle and states for the eprom programming sequencer
package uvep_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int WORDS = 1024;
  localparam int LOOP_W = 10;
  localparam int TMR_W = 17;
  localparam int UNITS_W = 4;
  localparam int CLK_NS = 10;
  // pin timing in ns, device figures
  localparam int T_AS_NS = 10000;
  localparam int T_CSS_NS = 10000;
  localparam int T_AH_NS = 1000;
  localparam int T_DH_NS = 1000;
  localparam int T_CH_NS = 500;
  localparam int PROGRAM_TO_READ_DELAY_NS = 10000;
  localparam int T_ACC_NS = 450;
  // pulse width step of 0.1 ms, total pulse time 100 ms in those steps
  localparam int PULSE_UNIT_NS = 100000;
  localparam int TOTAL_UNITS = 1000;
  localparam int MIN_UNITS = 1;
  localparam int MAX_UNITS = 10;
  // cycle counts, least times rounded up
  localparam int T_AS_CYC = (T_AS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_CSS_CYC = (T_CSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_AH_CYC = (T_AH_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_DH_CYC = (T_DH_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_CH_CYC = (T_CH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROGRAM_TO_READ_DELAY_CYC = (PROGRAM_TO_READ_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_UNIT_CYC = (PULSE_UNIT_NS + CLK_NS - 1) / CLK_NS;
  // extra cycles: image memory latency and input synchroniser depth
  localparam int MEM_LAT_CYC = 2;
  localparam int SYNC_CYC = 2;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
  localparam logic [ADDR_W-1:0] TOP_ADDR = 10'h3FF;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic dataOe;
    logic strobe;
    logic pulse;
    logic pulseOe;
  } uvep_pins_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PULSE,
    ST_HOLD,
    ST_EXIT,
    ST_READ
  } uvep_state_e;
endpackage

// [verilog/uvep_image_mem.sv]
// image memory, 1024 bytes, unwritten words read as erased
`timescale 1ns/10ps
module uvep_image_mem (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic wrEn,
  input wire logic [uvep_pkg::ADDR_W-1:0] wrAddr,
  input wire logic [uvep_pkg::DATA_W-1:0] wrData,
  input wire logic [uvep_pkg::ADDR_W-1:0] rdAddr,
  output logic [uvep_pkg::DATA_W-1:0] rdData
);
  import uvep_pkg::*;

  logic [DATA_W-1:0] mem [WORDS];
  logic [WORDS-1:0] written_reg;
  logic [DATA_W-1:0] rdData_reg;
  wire logic hit = written_reg[rdAddr];

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      written_reg <= '0;
    end else if (wrEn) begin
      written_reg[wrAddr] <= 1'b1;
    end
  end

  // don't-care words go out as all ones
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdData_reg <= ERASED_BYTE;
    end else begin
      rdData_reg <= hit ? mem[rdAddr] : ERASED_BYTE;
    end
  end

  assign rdData = rdData_reg;
endmodule

// [verilog/uvep_programmer.sv]
// programmer sequencer driving a 1024 x 8 uv eprom through its pins
`timescale 1ns/10ps
module uvep_programmer #(
  parameter int PULSE_UNIT_CYC = uvep_pkg::PULSE_UNIT_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic imgWrEn,
  input wire logic [uvep_pkg::ADDR_W-1:0] imgWrAddr,
  input wire logic [uvep_pkg::DATA_W-1:0] imgWrData,
  input wire logic startReq,
  input wire logic [uvep_pkg::UNITS_W-1:0] pulseUnits,
  input wire logic rdReq,
  input wire logic [uvep_pkg::ADDR_W-1:0] rdAddr,
  input wire logic [uvep_pkg::DATA_W-1:0] devData,
  output uvep_pkg::uvep_pins_s pins,
  output logic busy,
  output logic done,
  output logic rdValid,
  output logic [uvep_pkg::DATA_W-1:0] rdData,
  output logic [uvep_pkg::LOOP_W-1:0] loopIdx
);
  import uvep_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [UNITS_W-1:0] clamp_units(
    input logic [UNITS_W-1:0] u
  );
    if (u < UNITS_W'(MIN_UNITS)) begin
      return UNITS_W'(MIN_UNITS);
    end else if (u > UNITS_W'(MAX_UNITS)) begin
      return UNITS_W'(MAX_UNITS);
    end
    return u;
  endfunction

  // loops = ceil(100 ms / width)
  function automatic logic [LOOP_W-1:0] loops_for(
    input logic [UNITS_W-1:0] u
  );
    return LOOP_W'((TOTAL_UNITS + int'(u) - 1) / int'(u));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // constant timer loads
  localparam logic [TMR_W-1:0] LD_SETUP =
    TMR_W'(((T_AS_CYC > T_CSS_CYC) ? T_AS_CYC : T_CSS_CYC) + MEM_LAT_CYC);
  localparam logic [TMR_W-1:0] LD_HOLD =
    TMR_W'(((T_AH_CYC > T_DH_CYC) ? T_AH_CYC : T_DH_CYC) + T_CH_CYC);
  localparam logic [TMR_W-1:0] LD_EXIT = TMR_W'(PROGRAM_TO_READ_DELAY_CYC);
  localparam logic [TMR_W-1:0] LD_READ = TMR_W'(T_ACC_CYC + SYNC_CYC);

  ////////////////////////////////////////////////////////////////////////
  // state
  uvep_state_e state_reg, state_next;
  uvep_pins_s pins_reg, pins_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic [TMR_W-1:0] pulseCyc_reg, pulseCyc_next;
  logic [LOOP_W-1:0] loop_reg, loop_next;
  logic [LOOP_W-1:0] loopTop_reg, loopTop_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic rdValid_reg, rdValid_next;
  logic [DATA_W-1:0] rdData_reg, rdData_next;
  logic [DATA_W-1:0] devMeta_reg, devSync_reg;
  logic [DATA_W-1:0] memQ;

  wire logic tmrZero = (tmr_reg == '0);
  wire logic lastAddr = (pins_reg.addr == TOP_ADDR);
  wire logic lastLoop = (loop_reg == loopTop_reg - LOOP_W'(1));
  wire logic [UNITS_W-1:0] unitsEff = clamp_units(pulseUnits);
  wire logic [TMR_W-1:0] pulseLoad =
    TMR_W'(int'(unitsEff) * PULSE_UNIT_CYC);

  ////////////////////////////////////////////////////////////////////////
  // image memory, read at the address on the pins
  uvep_image_mem u_mem (
    .core_clk(core_clk),
    .rstn(rstn),
    .wrEn(imgWrEn),
    .wrAddr(imgWrAddr),
    .wrData(imgWrData),
    .rdAddr(pins_reg.addr),
    .rdData(memQ)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_next = state_reg;
    pins_next = pins_reg;
    tmr_next = tmrZero ? tmr_reg : tmr_reg - TMR_W'(1);
    pulseCyc_next = pulseCyc_reg;
    loop_next = loop_reg;
    loopTop_next = loopTop_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    rdValid_next = 1'b0;
    rdData_next = rdData_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (startReq) begin
          pins_next.strobe = 1'b1;
          pins_next.dataOe = 1'b1;
          pins_next.addr = '0;
          loop_next = '0;
          loopTop_next = loops_for(unitsEff);
          pulseCyc_next = pulseLoad - TMR_W'(1);
          tmr_next = LD_SETUP;
          busy_next = 1'b1;
          state_next = ST_SETUP;
        end else if (rdReq) begin
          pins_next.addr = rdAddr;
          tmr_next = LD_READ;
          busy_next = 1'b1;
          state_next = ST_READ;
        end
      end
      ST_SETUP: begin
        pins_next.data = memQ;
        if (tmrZero) begin
          pins_next.pulse = 1'b1;
          tmr_next = pulseCyc_reg;
          state_next = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (tmrZero) begin
          pins_next.pulse = 1'b0;
          tmr_next = LD_HOLD;
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tmrZero) begin
          if (lastAddr && lastLoop) begin
            pins_next.strobe = 1'b0;
            pins_next.dataOe = 1'b0;
            tmr_next = LD_EXIT;
            state_next = ST_EXIT;
          end else begin
            pins_next.addr = pins_reg.addr + ADDR_W'(1);
            if (lastAddr) begin
              loop_next = loop_reg + LOOP_W'(1);
            end
            tmr_next = LD_SETUP;
            state_next = ST_SETUP;
          end
        end
      end
      ST_EXIT: begin
        if (tmrZero) begin
          busy_next = 1'b0;
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_READ: begin
        if (tmrZero) begin
          rdData_next = devSync_reg;
          rdValid_next = 1'b1;
          busy_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      devMeta_reg <= '0;
      devSync_reg <= '0;
    end else begin
      devMeta_reg <= devData;
      devSync_reg <= devMeta_reg;
    end
  end

  // pulse pin driven low from reset on
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      pins_reg <= '{addr: '0, data: ERASED_BYTE, dataOe: 1'b0,
                    strobe: 1'b0, pulse: 1'b0, pulseOe: 1'b1};
      tmr_reg <= '0;
    end else begin
      state_reg <= state_next;
      pins_reg <= pins_next;
      tmr_reg <= tmr_next;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pulseCyc_reg <= '0;
      loop_reg <= '0;
      loopTop_reg <= '0;
    end else begin
      pulseCyc_reg <= pulseCyc_next;
      loop_reg <= loop_next;
      loopTop_reg <= loopTop_next;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      rdValid_reg <= 1'b0;
      rdData_reg <= '0;
    end else begin
      busy_reg <= busy_next;
      done_reg <= done_next;
      rdValid_reg <= rdValid_next;
      rdData_reg <= rdData_next;
    end
  end

  assign pins = pins_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign rdValid = rdValid_reg;
  assign rdData = rdData_reg;
  assign loopIdx = loop_reg;
endmodule

// [sim/uvep_dev_model.sv]
// behavioural uv eprom on the far side of the programmer
`timescale 1ns/10ps
module uvep_dev_model (
  input wire uvep_pkg::uvep_pins_s pins,
  output logic [uvep_pkg::DATA_W-1:0] devData
);
  import uvep_pkg::*;
  logic [DATA_W-1:0] mem [WORDS];
  initial begin
    for (int i = 0; i < WORDS; i++) mem[i] = ERASED_BYTE;
  end
  // bits only clear, one pulse at a time
  always @(posedge pins.pulse) begin
    if (pins.strobe && pins.dataOe) begin
      mem[pins.addr] <= mem[pins.addr] & pins.data;
    end
  end
  // outputs off while programming: show the inverse
  assign devData = pins.strobe ? ~mem[pins.addr] : mem[pins.addr];
endmodule

// [sim/uvep_programmer_chk.sv]
// assertions on the programmer pin sequence and read timing
`timescale 1ns/10ps
module uvep_programmer_chk #(
  parameter int PULSE_UNIT_CYC = 10
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic startReq,
  input wire logic rdReq,
  input wire uvep_pkg::uvep_pins_s pins,
  input wire logic busy,
  input wire logic done,
  input wire logic rdValid
);
  import uvep_pkg::*;
  logic [ADDR_W-1:0] addrLast_reg;
  logic pulseLast_reg;
  logic [1:0] pulseCnt_reg;
  logic [1:0] pulseCnt_next;
  logic [TMR_W-1:0] pwCnt_reg;
  wire newAddr = !pins.strobe || pins.addr != addrLast_reg;
  wire pulseRise = pins.pulse && !pulseLast_reg;
  assign pulseCnt_next = newAddr ? 2'h0 : pulseCnt_reg + {1'b0, pulseRise};
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      addrLast_reg <= '0;
      pulseLast_reg <= 1'b0;
      pulseCnt_reg <= 2'h0;
      pwCnt_reg <= '0;
    end else begin
      addrLast_reg <= pins.addr;
      pulseLast_reg <= pins.pulse;
      pulseCnt_reg <= pulseCnt_next;
      pwCnt_reg <= pins.pulse ? pwCnt_reg + TMR_W'(1) : '0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_PULSE_IN_MODE:
    assert property (pins.pulse |-> pins.strobe && pins.dataOe)
      else $error("pulse outside program mode");
  AST_ONE_PULSE:
    assert property (pulseCnt_reg <= 2'h1) else $error("second pulse");
  AST_SETUP:
    assert property ($rose(pins.pulse) |-> $past(pins.strobe, 8) &&
      $past(pins.addr, 8) == pins.addr) else $error("no setup");
  AST_STABLE_IN_PULSE:
    assert property (pins.pulse |=> $stable(pins.addr) && $stable(pins.data))
      else $error("pins move in pulse");
  AST_HOLD:
    assert property ($fell(pins.pulse) |-> $stable(pins.addr) [*8])
      else $error("address hold short");
  AST_ADDR_ASCENDS:
    assert property (pins.strobe && $past(pins.strobe) && $changed(pins.addr)
      |-> pins.addr == $past(pins.addr) + 10'h1) else $error("address skip");
  AST_EXIT_ORDER:
    assert property ($fell(pins.strobe) |-> pins.addr == TOP_ADDR &&
      $stable(pins.addr) && !pins.pulse) else $error("bad exit");
  AST_PULSE_MAX:
    assert property (pwCnt_reg <= TMR_W'(MAX_UNITS * PULSE_UNIT_CYC))
      else $error("pulse too long");
  AST_PULSE_MIN:
    assert property ($fell(pins.pulse) |-> pwCnt_reg >=
      TMR_W'(MIN_UNITS * PULSE_UNIT_CYC)) else $error("pulse too short");
  AST_PULSE_DRIVEN:
    assert property (pins.pulseOe) else $error("pulse pin floats");
  AST_READ_TIME:
    assert property (rdReq && !startReq && !busy && !done && !rdValid
      |-> ##[48:51] rdValid) else $error("read late");
  cover property ($rose(pins.pulse));
  cover property ($fell(pins.pulse) && pins.data == 8'hFF);
  cover property (rdValid);
endmodule
bind uvep_programmer uvep_programmer_chk #(.PULSE_UNIT_CYC(PULSE_UNIT_CYC))
  chk_i (.core_clk(core_clk), .rstn(rstn), .startReq(startReq),
  .rdReq(rdReq), .pins(pins), .busy(busy), .done(done), .rdValid(rdValid));

// [sim/tb_top.sv]
// self-checking bench for the eprom programming sequencer
`timescale 1ns/10ps
module tb_top;
  import uvep_pkg::*;
  localparam int PU = 10;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic imgWrEn = 1'b0;
  logic [ADDR_W-1:0] imgWrAddr = '0;
  logic [DATA_W-1:0] imgWrData = '0;
  logic startReq = 1'b0;
  logic [UNITS_W-1:0] pulseUnits = '0;
  logic rdReq = 1'b0;
  logic [ADDR_W-1:0] rdAddr = '0;
  logic [DATA_W-1:0] devData, rdData;
  uvep_pins_s pins;
  logic busy, done, rdValid;
  logic [LOOP_W-1:0] loopIdx;
  int n_errors = 0;
  int checks = 0;
  int seed = 32'hA14D96E7;
  int pw = 0;
  logic [31:0] pq[$];
  logic [7:0] rq[$];
  logic [7:0] img [4] = '{8'h5A, 8'h3C, 8'h00, 8'h00};
  logic [7:0] ex [4] = '{default: 8'hFF};
  uvep_programmer #(.PULSE_UNIT_CYC(PU)) uvep_programmer_i (
    .core_clk(core_clk), .rstn(rstn), .imgWrEn(imgWrEn),
    .imgWrAddr(imgWrAddr), .imgWrData(imgWrData), .startReq(startReq),
    .pulseUnits(pulseUnits), .rdReq(rdReq), .rdAddr(rdAddr),
    .devData(devData), .pins(pins), .busy(busy), .done(done),
    .rdValid(rdValid), .rdData(rdData), .loopIdx(loopIdx));
  uvep_dev_model uvep_dev_model_i (.pins(pins), .devData(devData));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (pq.size() + rq.size() != 0) n_errors++;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // four addresses of one pass, then reset in mid-run
  task automatic run(input logic [3:0] u);
    int w;
    int n = 0;
    w = ((u == 4'h0) ? 1 : (u > 4'hA) ? 10 : int'(u)) * PU;
    for (int a = 0; a < 4; a++) begin
      imgWrEn = (a != 1);
      imgWrAddr = a[9:0];
      imgWrData = img[a];
      if (a != 1) ex[a] = ex[a] & img[a];
      pq.push_back({a[9:0], (a == 1) ? 8'hFF : img[a], w[13:0]});
      tick();
    end
    imgWrEn = 1'b0;
    pulseUnits = u;
    startReq = 1'b1;
    tick();
    startReq = 1'b0;
    while (pq.size() != 0 && n < 6000) begin
      tick();
      n++;
    end
    if (n == 6000) begin
      n_errors++;
      end_of_test();
    end
    rstn = 1'b0;
    repeat (3) tick();
    cmp({10'h0, pins}, {20'h0, ERASED_BYTE, 4'h1});
    cmp({19'h0, busy, done, rdValid, loopIdx}, 32'h0);
    rstn = 1'b1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    int n = 0;
    rq.push_back((a < 4) ? ex[a] : 8'hFF);
    rdReq = 1'b1;
    rdAddr = a;
    tick();
    rdReq = 1'b0;
    tick();
    while (busy !== 1'b0 && n < 100) begin
      tick();
      n++;
    end
    if (n == 100) begin
      n_errors++;
      end_of_test();
    end
  endtask
  // pulse width, address and data seen at each pulse end; read data
  always @(posedge core_clk) begin
    if (!rstn) begin
      pw = 0;
    end else if (pins.pulse === 1'b1) begin
      pw++;
    end else if (pw != 0) begin
      cmp({pins.addr, pins.data, 14'(pw)},
        (pq.size() != 0) ? pq.pop_front() : '1);
      cmp({20'h0, busy, done, loopIdx}, {20'h0, 2'h2, 10'h0});
      pw = 0;
    end
    if (rdValid === 1'b1) begin
      cmp({24'h0, rdData}, (rq.size() != 0) ? {24'h0, rq.pop_front()} : '1);
      cmp({31'h0, busy}, 32'h0);
    end
  end
  initial begin
    img[3] = 8'($random(seed));
    repeat (20) tick();
    rstn = 1'b1;
    run(4'hC);
    img[3] = 8'($random(seed));
    run(4'h0);
    for (int a = 0; a < 6; a++) begin
      rd(a[9:0]);
    end
    tick();
    end_of_test();
  end
endmodule
